// File: rtl/motion_event_defs.vh
// register map, field positions, reset values and timing constants of the motion event block
`ifndef MOTION_EVENT_DEFS_VH
`define MOTION_EVENT_DEFS_VH
// register word indices (byte address = index * 4)
`define IDX_REL          8'h1a
`define IDX_CTRL1        8'h1b
`define IDX_CTRL2        8'h1c
`define IDX_CTRL3        8'h1d
`define IDX_CTRL4        8'h1e
`define IDX_CTRL5        8'h1f
`define IDX_INTCTL1      8'h22
`define IDX_INTCTL2      8'h23
`define IDX_INTCTL3      8'h24
`define IDX_STATUS       8'h15
`define IDX_EVSTAT1      8'h16
`define IDX_EVSTAT2      8'h17
`define IDX_EVSTAT3      8'h18
`define IDX_FREEFALL_THRESHOLD_REGISTER         8'h32
`define IDX_FFCNT        8'h33
`define IDX_FFCTL        8'h34
`define IDX_WUTH         8'h30
`define IDX_WUTMR        8'h31
`define IDX_TILTTMR      8'h29
`define IDX_TILTANG      8'h2a
`define IDX_TAPLO        8'h2b
`define IDX_TAPHI        8'h2c
`define IDX_ODR          8'h2d
`define IDX_ACCX         8'h40
`define IDX_ACCY         8'h41
`define IDX_ACCZ         8'h42
`define IDX_TAPIN        8'h43
// control 1 bits
`define CTRL1_TILT       0
`define CTRL1_TAP        2
// control 4 bits
`define CTRL4_SLEEP      6
`define CTRL4_WAKE       7
// control 5 bits
`define CTRL5_MANSLEEP   0
// interrupt control 1 bits
`define INT_LATCH_SEL    3
`define INT_POLARITY     4
`define INT_PIN_EN       5
// free-fall control bit
`define FFCTL_EN         7
// status bits
`define STATUS_INT       4
`define STATUS_WAKE      0
// event status 3 bits
`define EV3_WAKE         3
`define EV3_SLEEP        4
`define EV3_FREEFALL     7
`define EV3_TAP          2
`define EV3_TILT         0
// reset values
`define RST_ODR          8'h04
`define RST_TILTANG      8'h0c
// timing
`define CLK_HZ           20000000
`define PULSE_NS         50000
`define PULSE_CYC        ((`PULSE_NS * (`CLK_HZ / 1000000)) / 1000)
`define APB_UNMAPPED     32'h0000_0000
`endif

// File: rtl/rate_tick.v
// divider that makes one tick per period of a programmed output data rate
`timescale 1ns/1ps
module rate_tick #(
    parameter DIV_W = 16
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // rate code: period = (code + 1) * 256 cycles
    input  wire [7:0]       rate_code,
    // one tick per period
    output reg              tick
);
    reg  [DIV_W-1:0] count;
    wire [DIV_W-1:0] limit = {rate_code, 8'hff};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {DIV_W{1'b0}};
            tick  <= 1'b0;
        end else if (count >= limit) begin
            count <= {DIV_W{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

// File: rtl/motion_event_interrupt_control.v
// motion event engines, their control registers and the interrupt pin behind an apb slave
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "motion_event_defs.vh"
module motion_event_interrupt_control (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // interrupt pin
    output reg         int_pin
);
    // registers
    reg  [7:0]  ctrl1;
    reg  [7:0]  ctrl2;
    reg  [7:0]  ctrl3;
    reg  [7:0]  ctrl4;
    reg  [7:0]  ctrl5;
    reg  [7:0]  intctl1;
    reg  [7:0]  intctl2;
    reg  [7:0]  intctl3;
    reg  [7:0]  freefall_threshold_register;
    reg  [7:0]  ffcnt;
    reg  [7:0]  ffctl;
    reg  [7:0]  wuth;
    reg  [7:0]  wutmr;
    reg  [7:0]  tilttmr;
    reg  [7:0]  tiltang;
    reg  [7:0]  taplo;
    reg  [7:0]  taphi;
    reg  [7:0]  odr;
    // host-written stand-ins for sensor data, then the event status registers
    reg  [7:0]  accx;
    reg  [7:0]  accy;
    reg  [7:0]  accz;
    reg  [7:0]  tapin;
    reg  [7:0]  evstat1;
    reg  [7:0]  evstat2;
    reg  [7:0]  evstat3;
    // engine state
    reg         wake_state;
    reg  [7:0]  wake_cnt;
    reg  [7:0]  ff_cnt;
    reg  [7:0]  tilt_cnt;
    reg  [5:0]  tilt_pos;
    reg  [5:0]  tilt_cand;
    reg         int_level;
    reg         pulse_busy;
    reg  [15:0] pulse_cnt;
    reg         prev_evt;
    wire        tick_wake;
    wire        tick_tilt;
    wire        tick_tap;
    wire        tick_ff;
    wire        setup = psel && !penable;
    wire        acc_en = psel && penable;
    wire        wr = acc_en && pwrite;
    wire        rd = acc_en && !pwrite;
    wire [7:0]  widx = paddr[9:2];
    wire [7:0]  wd = pwdata[7:0];
    wire        release_rd = rd && (widx == `IDX_REL);
    wire        manual_sleep = wr && (widx == `IDX_CTRL5) && wd[`CTRL5_MANSLEEP];

    function [7:0] absval;
        input [7:0] v;
        begin
            absval = v[7] ? (~v + 8'h01) : v;
        end
    endfunction

    function known;
        input [7:0] a;
        begin
            case (a)
                `IDX_REL, `IDX_CTRL1, `IDX_CTRL2, `IDX_CTRL3, `IDX_CTRL4, `IDX_CTRL5,
                `IDX_INTCTL1, `IDX_INTCTL2, `IDX_INTCTL3, `IDX_STATUS, `IDX_EVSTAT1,
                `IDX_EVSTAT2, `IDX_EVSTAT3, `IDX_FREEFALL_THRESHOLD_REGISTER, `IDX_FFCNT, `IDX_FFCTL, `IDX_WUTH,
                `IDX_WUTMR, `IDX_TILTTMR, `IDX_TILTANG, `IDX_TAPLO, `IDX_TAPHI, `IDX_ODR,
                `IDX_ACCX, `IDX_ACCY, `IDX_ACCZ, `IDX_TAPIN: known = 1'b1;
                default: known = 1'b0;
            endcase
        end
    endfunction

    // per-engine data rate ticks
    rate_tick #(.DIV_W(16)) u_wake (.pclk(pclk), .presetn(presetn), .rate_code({4'h0, odr[3:0]}),
        .tick(tick_wake));
    rate_tick #(.DIV_W(16)) u_tilt (.pclk(pclk), .presetn(presetn), .rate_code({4'h0, odr[7:4]}),
        .tick(tick_tilt));
    rate_tick #(.DIV_W(16)) u_tap (.pclk(pclk), .presetn(presetn), .rate_code({4'h0, ctrl3[3:0]}),
        .tick(tick_tap));
    rate_tick #(.DIV_W(16)) u_ff (.pclk(pclk), .presetn(presetn), .rate_code({5'h00, ffctl[2:0]}),
        .tick(tick_ff));

    // wake-up axis test over unmasked axes
    wire over_wake = (intctl2[0] && absval(accx) > wuth) ||
                     (intctl2[1] && absval(accy) > wuth) ||
                     (intctl2[2] && absval(accz) > wuth);
    wire under_ff = absval(accx) < freefall_threshold_register && absval(accy) < freefall_threshold_register && absval(accz) < freefall_threshold_register;
    // tilt orientation: one-hot of six faces, z faces when z beyond angle
    wire [5:0] orient = (absval(accz) > tiltang) ? (accz[7] ? 6'h01 : 6'h02) :
                        (absval(accx) >= absval(accy)) ? (accx[7] ? 6'h20 : 6'h10) :
                        (accy[7] ? 6'h08 : 6'h04);
    wire tap_ok = (tapin > taplo) && (tapin < taphi);
    wire [5:0] tap_dir = orient & intctl3[5:0];

    // engine events
    reg         ev_wake;
    reg         ev_sleep;
    reg         ev_ff;
    reg         ev_tilt;
    reg         ev_tap;
    always @* begin
        ev_wake  = ctrl4[`CTRL4_WAKE] && tick_wake && over_wake &&
                   (wake_cnt + 8'h01 >= wutmr) && !wake_state;
        ev_sleep = ctrl4[`CTRL4_SLEEP] && tick_wake && !over_wake && wake_state &&
                   (wake_cnt + 8'h01 >= wutmr);
        ev_ff    = ffctl[`FFCTL_EN] && tick_ff && under_ff && (ff_cnt + 8'h01 >= ffcnt);
        ev_tilt  = ctrl1[`CTRL1_TILT] && tick_tilt && orient == tilt_cand && orient != tilt_pos &&
                   (tilt_cnt + 8'h01 >= tilttmr) && |(orient & ctrl2[5:0]);
        ev_tap   = ctrl1[`CTRL1_TAP] && tick_tap && tap_ok && |tap_dir;
    end
    wire any_evt = ev_wake | ev_sleep | ev_ff | ev_tilt | ev_tap;

    // engine timers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt  <= 8'h00;
            ff_cnt    <= 8'h00;
            tilt_cnt  <= 8'h00;
            tilt_pos  <= 6'h00;
            tilt_cand <= 6'h00;
            wake_state <= 1'b0;
        end else begin
            if (!ctrl4[`CTRL4_WAKE] && !ctrl4[`CTRL4_SLEEP])
                wake_cnt <= 8'h00;
            else if (tick_wake) begin
                if (ev_wake || ev_sleep || (over_wake == wake_state))
                    wake_cnt <= 8'h00;
                else
                    wake_cnt <= wake_cnt + 8'h01;
            end
            if (ev_wake)
                wake_state <= 1'b1;
            else if (manual_sleep || ev_sleep)
                wake_state <= 1'b0;
            if (!ffctl[`FFCTL_EN])
                ff_cnt <= 8'h00;
            else if (tick_ff)
                ff_cnt <= (under_ff && !ev_ff) ? ff_cnt + 8'h01 : 8'h00;
            if (!ctrl1[`CTRL1_TILT]) begin
                tilt_cnt <= 8'h00;
            end else if (tick_tilt) begin
                if (orient != tilt_cand) begin
                    tilt_cand <= orient;
                    tilt_cnt  <= 8'h00;
                end else if (tilt_cnt + 8'h01 >= tilttmr) begin
                    tilt_pos <= orient;
                    tilt_cnt <= 8'h00;
                end else begin
                    tilt_cnt <= tilt_cnt + 8'h01;
                end
            end
        end
    end

    // apb register access; sticky flags, set wins over release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ctrl1, ctrl2, ctrl3, ctrl4, ctrl5} <= {5{8'h00}};
            {intctl1, intctl2, intctl3} <= {3{8'h00}};
            {freefall_threshold_register, ffcnt, ffctl, wuth, wutmr, tilttmr, taplo, taphi} <= {8{8'h00}};
            {accx, accy, accz, tapin} <= {4{8'h00}};
            tiltang <= `RST_TILTANG;
            odr     <= `RST_ODR;
            {evstat1, evstat2, evstat3} <= {3{8'h00}};
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !known(paddr[9:2]);
            if (wr && pready) begin
                case (widx)
                    `IDX_CTRL1:   ctrl1   <= wd;
                    `IDX_CTRL2:   ctrl2   <= wd;
                    `IDX_CTRL3:   ctrl3   <= wd;
                    `IDX_CTRL4:   ctrl4   <= wd;
                    `IDX_CTRL5:   ctrl5   <= wd & 8'hfe;
                    `IDX_INTCTL1: intctl1 <= wd;
                    `IDX_INTCTL2: intctl2 <= wd;
                    `IDX_INTCTL3: intctl3 <= wd;
                    `IDX_FREEFALL_THRESHOLD_REGISTER:    freefall_threshold_register    <= wd;
                    `IDX_FFCNT:   ffcnt   <= wd;
                    `IDX_FFCTL:   ffctl   <= wd;
                    `IDX_WUTH:    wuth    <= wd;
                    `IDX_WUTMR:   wutmr   <= wd;
                    `IDX_TILTTMR: tilttmr <= wd;
                    `IDX_TILTANG: tiltang <= wd;
                    `IDX_TAPLO:   taplo   <= wd;
                    `IDX_TAPHI:   taphi   <= wd;
                    `IDX_ODR:     odr     <= wd;
                    `IDX_ACCX:    accx    <= wd;
                    `IDX_ACCY:    accy    <= wd;
                    `IDX_ACCZ:    accz    <= wd;
                    `IDX_TAPIN:   tapin   <= wd;
                    default: ;
                endcase
            end
            if (release_rd && pready) begin
                evstat1 <= ev_tap ? {2'b00, tap_dir} : 8'h00;
                evstat2 <= ev_tilt ? {2'b00, orient} : 8'h00;
                evstat3 <= {ev_ff, 2'b00, ev_sleep, ev_wake, ev_tap, 1'b0, ev_tilt};
            end else begin
                if (ev_tap)
                    evstat1 <= evstat1 | {2'b00, tap_dir};
                if (ev_tilt)
                    evstat2 <= {2'b00, orient};
                evstat3 <= evstat3 | {ev_ff, 2'b00, ev_sleep, ev_wake, ev_tap, 1'b0, ev_tilt};
            end
            if (setup && !pwrite) begin // read data stands by the access edge
                case (widx)
                    `IDX_CTRL1:   prdata <= {24'h0, ctrl1};
                    `IDX_CTRL2:   prdata <= {24'h0, ctrl2};
                    `IDX_CTRL3:   prdata <= {24'h0, ctrl3};
                    `IDX_CTRL4:   prdata <= {24'h0, ctrl4};
                    `IDX_CTRL5:   prdata <= {24'h0, ctrl5};
                    `IDX_INTCTL1: prdata <= {24'h0, intctl1};
                    `IDX_INTCTL2: prdata <= {24'h0, intctl2};
                    `IDX_INTCTL3: prdata <= {24'h0, intctl3};
                    `IDX_STATUS:  prdata <= {27'h0, |evstat3, 3'h0, wake_state};
                    `IDX_EVSTAT1: prdata <= {24'h0, evstat1};
                    `IDX_EVSTAT2: prdata <= {24'h0, evstat2};
                    `IDX_EVSTAT3: prdata <= {24'h0, evstat3};
                    `IDX_FREEFALL_THRESHOLD_REGISTER:    prdata <= {24'h0, freefall_threshold_register};
                    `IDX_FFCNT:   prdata <= {24'h0, ffcnt};
                    `IDX_FFCTL:   prdata <= {24'h0, ffctl};
                    `IDX_WUTH:    prdata <= {24'h0, wuth};
                    `IDX_WUTMR:   prdata <= {24'h0, wutmr};
                    `IDX_TILTTMR: prdata <= {24'h0, tilttmr};
                    `IDX_TILTANG: prdata <= {24'h0, tiltang};
                    `IDX_TAPLO:   prdata <= {24'h0, taplo};
                    `IDX_TAPHI:   prdata <= {24'h0, taphi};
                    `IDX_ODR:     prdata <= {24'h0, odr};
                    `IDX_ACCX:    prdata <= {24'h0, accx};
                    `IDX_ACCY:    prdata <= {24'h0, accy};
                    `IDX_ACCZ:    prdata <= {24'h0, accz};
                    `IDX_TAPIN:   prdata <= {24'h0, tapin};
                    default:      prdata <= `APB_UNMAPPED;
                endcase
            end
        end
    end

    // interrupt pin: latched level or fixed pulse, gated and polarised
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_level  <= 1'b0;
            pulse_busy <= 1'b0;
            pulse_cnt  <= 16'h0000;
            prev_evt   <= 1'b0;
            int_pin    <= 1'b1;
        end else begin
            prev_evt <= any_evt;
            if (any_evt)
                int_level <= 1'b1;
            else if (release_rd && pready)
                int_level <= 1'b0;
            if (any_evt && !prev_evt) begin
                pulse_busy <= 1'b1;
                pulse_cnt  <= 16'h0000;
            end else if (pulse_busy) begin
                if (pulse_cnt == `PULSE_CYC - 1)
                    pulse_busy <= 1'b0;
                pulse_cnt <= pulse_cnt + 16'h0001;
            end
            int_pin <= ((intctl1[`INT_PIN_EN] &&
                        (intctl1[`INT_LATCH_SEL] ? pulse_busy : int_level))
                        ^ ~intctl1[`INT_POLARITY]);
        end
    end
endmodule

// File: bench/motion_event_props.sv
// assertions on the apb port and interrupt pin of the motion event block
`timescale 1ns/1ps
`include "motion_event_defs.vh"
module motion_event_props (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // interrupt pin
    input wire        int_pin
);
    logic [7:0]  ctl;
    logic [11:0] cnt;
    wire         done = psel && penable && pready;
    wire         rel  = done && !pwrite && paddr[9:2] == `IDX_REL;
    wire         act  = int_pin == ctl[`INT_POLARITY];
    // shadow of interrupt control 1, taken from completed writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 8'h00;
            cnt <= 12'h000;
        end else begin
            if (done && pwrite && paddr[9:2] == `IDX_INTCTL1) begin
                ctl <= pwdata[7:0];
            end
            cnt <= (act && ctl[3] && ctl[5]) ? cnt + 12'h001 : 12'h000;
        end
    end
    setup_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready) else $error("no answer after setup");
    ready_single_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready longer than one cycle");
    err_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready && psel && penable) else $error("pslverr outside access");
    unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped read not zero");
    rdata_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
    upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    pin_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl[5] ##1 (!ctl[5] && $stable(ctl)) |-> !act) else $error("disabled pin active");
    pulse_max_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt <= `PULSE_CYC) else $error("pulse too long");
    pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(act) && ctl[3] && ctl[5] && ctl == $past(ctl, 2) |-> cnt == `PULSE_CYC)
        else $error("pulse length wrong");
    release_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        rel && ctl[5] && !ctl[3] |-> ##[1:2] !act) else $error("pin kept after release");
    cover property (@(posedge pclk) rel && act);
    cover property (@(posedge pclk) $fell(act) && ctl[3]);
    cover property (@(posedge pclk) pslverr);
endmodule
bind motion_event_interrupt_control motion_event_props motion_event_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_pin(int_pin));

// File: bench/apb_host_model.sv
// apb master standing in for the host microcontroller
`timescale 1ns/1ps
module apb_host_model (
    // clock
    input  wire         pclk,
    // apb
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input  wire  [31:0] prdata,
    input  wire         pready,
    input  wire         pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end
    // one transfer to register word idx; a released bus shows inverted address and write data
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd, output logic err);
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= {2'b00, idx, 2'b00};
            pwdata  <= {24'h0, wd};
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            paddr   <= ~paddr;
            pwdata  <= ~pwdata;
        end
    endtask
endmodule

// File: bench/motion_event_interrupt_control_test.sv
// self-checking testbench of the motion event block
`timescale 1ns/1ps
`include "motion_event_defs.vh"
module motion_event_interrupt_control_test;
    logic        pclk;
    logic        presetn;
    wire         psel;
    wire         penable;
    wire         pwrite;
    wire  [11:0] paddr;
    wire  [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         int_pin;
    int          mismatches;
    int          n_tests;
    int          low_cnt = 0;
    logic        count_en;
    logic [31:0] rv;
    logic        ev;
    motion_event_interrupt_control motion_event_interrupt_control_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .int_pin(int_pin));
    apb_host_model apb_host_model_inst (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // active-low cycles of the pin while a pulse is measured
    always @(posedge pclk) begin
        if (count_en && int_pin === 1'b0) begin
            low_cnt <= low_cnt + 1;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb_host_model_inst.xfer(1'b1, idx, d, rv, ev);
    endtask
    task automatic rd(input logic [7:0] idx);
        apb_host_model_inst.xfer(1'b0, idx, 8'h00, rv, ev);
    endtask
    task automatic bitchk(input string what, input int b, input logic e);
        chk(what, {31'h0, e}, {31'h0, rv[b]});
    endtask
    task automatic pin(input logic e);
        chk("int_pin", {31'h0, e}, {31'h0, int_pin});
    endtask
    // read until bit b of register idx is set, bounded
    task automatic poll(input logic [7:0] idx, input int b);
        int n;
        n = 0;
        rd(idx);
        while (rv[b] !== 1'b1 && n < 800) begin
            rd(idx);
            n++;
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        end_sim;
    end
    initial begin
        presetn    = 1'b0;
        count_en   = 1'b0;
        mismatches = 0;
        n_tests    = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IDX_ODR);
        chk("rate reset", 32'h04, rv);
        rd(`IDX_TILTANG);
        chk("tilt angle reset", 32'h0c, rv);
        rd(8'h00);
        chk("unmapped data", 32'h0, rv);
        chk("unmapped err", 32'h1, {31'h0, ev});
        // arm every engine's parameters, engine enables clear, pin enabled active high, acceleration zero
        wr(`IDX_ODR, 8'h00);
        wr(`IDX_WUTH, 8'h10);
        wr(`IDX_WUTMR, 8'h01);
        wr(`IDX_TILTTMR, 8'h01);
        wr(`IDX_TAPLO, 8'h01);
        wr(`IDX_TAPHI, 8'hf0);
        wr(`IDX_TAPIN, 8'h40);
        wr(`IDX_INTCTL3, 8'h3f);
        wr(`IDX_FREEFALL_THRESHOLD_REGISTER, 8'h08);
        wr(`IDX_FFCNT, 8'h02);
        wr(`IDX_INTCTL1, 8'h30);
        repeat (1500) @(posedge pclk);
        rd(`IDX_EVSTAT3);
        chk("no event while disabled", 32'h0, rv);
        wr(`IDX_ACCX, 8'h40);
        wr(`IDX_INTCTL2, 8'h07);
        repeat (1500) @(posedge pclk);
        rd(`IDX_EVSTAT3);
        bitchk("wake while disabled", `EV3_WAKE, 1'b0);
        wr(`IDX_INTCTL2, 8'h00);
        wr(`IDX_CTRL4, 8'h80);
        repeat (1500) @(posedge pclk);
        rd(`IDX_EVSTAT3);
        bitchk("wake on masked axis", `EV3_WAKE, 1'b0);
        wr(`IDX_INTCTL2, 8'h07);
        poll(`IDX_EVSTAT3, `EV3_WAKE);
        bitchk("wake event", `EV3_WAKE, 1'b1);
        pin(1'b1);
        wr(`IDX_CTRL4, 8'h00);
        wr(`IDX_ACCX, 8'h00);
        rd(`IDX_STATUS);
        bitchk("wake state", `STATUS_WAKE, 1'b1);
        wr(`IDX_CTRL5, 8'h01);
        rd(`IDX_STATUS);
        bitchk("wake state after sleep", `STATUS_WAKE, 1'b0);
        rd(`IDX_REL);
        rd(`IDX_EVSTAT3);
        chk("status after release", 32'h0, rv);
        pin(1'b0);
        // free fall, latched active-high pin
        wr(`IDX_FFCTL, 8'h80);
        poll(`IDX_EVSTAT3, `EV3_FREEFALL);
        bitchk("free fall event", `EV3_FREEFALL, 1'b1);
        pin(1'b1);
        wr(`IDX_FFCTL, 8'h00);
        rd(`IDX_STATUS);
        bitchk("summary set", `STATUS_INT, 1'b1);
        rd(`IDX_REL);
        rd(`IDX_STATUS);
        bitchk("summary cleared", `STATUS_INT, 1'b0);
        rd(`IDX_EVSTAT3);
        chk("sources cleared", 32'h0, rv);
        pin(1'b0);
        // pin disabled: flag still latches and stays
        wr(`IDX_INTCTL1, 8'h10);
        wr(`IDX_FFCTL, 8'h80);
        poll(`IDX_EVSTAT3, `EV3_FREEFALL);
        pin(1'b0);
        wr(`IDX_FFCTL, 8'h00);
        repeat (1500) @(posedge pclk);
        rd(`IDX_EVSTAT3);
        bitchk("flag held", `EV3_FREEFALL, 1'b1);
        rd(`IDX_REL);
        // pulse mode, active low
        wr(`IDX_INTCTL1, 8'h28);
        repeat (2) @(posedge pclk);
        pin(1'b1);
        count_en <= 1'b1;
        wr(`IDX_FFCTL, 8'h80);
        poll(`IDX_EVSTAT3, `EV3_FREEFALL);
        wr(`IDX_FFCTL, 8'h00);
        repeat (1200) @(posedge pclk);
        chk("pulse cycles", `PULSE_CYC, low_cnt);
        rd(`IDX_REL);
        // back-to-sleep after a wake-up, latched active-high pin
        wr(`IDX_INTCTL1, 8'h30);
        wr(`IDX_ACCX, 8'h40);
        wr(`IDX_CTRL4, 8'hc0);
        poll(`IDX_EVSTAT3, `EV3_WAKE);
        wr(`IDX_ACCX, 8'h00);
        poll(`IDX_EVSTAT3, `EV3_SLEEP);
        bitchk("sleep event", `EV3_SLEEP, 1'b1);
        rd(`IDX_STATUS);
        bitchk("wake state after sleep event", `STATUS_WAKE, 1'b0);
        wr(`IDX_CTRL4, 8'h00);
        rd(`IDX_REL);
        // tap: masked direction, index above window, then accepted
        wr(`IDX_INTCTL3, 8'h2f);
        wr(`IDX_CTRL1, 8'h04);
        repeat (600) @(posedge pclk);
        rd(`IDX_EVSTAT3);
        bitchk("tap on masked direction", `EV3_TAP, 1'b0);
        wr(`IDX_INTCTL3, 8'h3f);
        wr(`IDX_TAPIN, 8'hf8);
        repeat (600) @(posedge pclk);
        rd(`IDX_EVSTAT3);
        bitchk("tap above high threshold", `EV3_TAP, 1'b0);
        wr(`IDX_TAPIN, 8'h40);
        poll(`IDX_EVSTAT3, `EV3_TAP);
        bitchk("tap event", `EV3_TAP, 1'b1);
        rd(`IDX_EVSTAT1);
        chk("tap direction", 32'h10, rv);
        wr(`IDX_CTRL1, 8'h00);
        rd(`IDX_REL);
        // tilt: all states masked, then a committed change to z up
        wr(`IDX_CTRL1, 8'h01);
        repeat (800) @(posedge pclk);
        rd(`IDX_EVSTAT3);
        bitchk("tilt into masked state", `EV3_TILT, 1'b0);
        wr(`IDX_CTRL2, 8'h3f);
        wr(`IDX_ACCZ, 8'h40);
        poll(`IDX_EVSTAT3, `EV3_TILT);
        bitchk("tilt event", `EV3_TILT, 1'b1);
        rd(`IDX_EVSTAT2);
        chk("tilt state", 32'h02, rv);
        wr(`IDX_CTRL1, 8'h00);
        rd(`IDX_REL);
        end_sim;
    end
endmodule
